// >>> design/rfxsc_params.svh
// constants for the rf supply, charge pump and transmit control registers
// assumes a 40 MHz system clock shared by both ends
`ifndef RFXSC_PARAMS_SVH
`define RFXSC_PARAMS_SVH
// link register addresses
`define RFXSC_ADDR_SUPPLY 4'h2
`define RFXSC_ADDR_XMT 4'h3
// supply and pump register fields
`define RFXSC_SUP_SRC_BIT 7
`define RFXSC_SUP_POL_BIT 6
`define RFXSC_SUP_CODE_BIT 5
`define RFXSC_SUP_CPT_HI 4
`define RFXSC_SUP_CPT_LO 3
`define RFXSC_SUP_ANALOG_SUPPLY_SELECT_BIT 2
`define RFXSC_SUP_CAP_BIT 1
`define RFXSC_SUP_PUMP_BIT 0
`define RFXSC_SUP_RESET 8'h04
// transmit control register fields
`define RFXSC_XMT_SEND_BIT 7
`define RFXSC_XMT_ERR_BIT 6
`define RFXSC_XMT_RTS_BIT 5
`define RFXSC_XMT_PWR_HI 4
`define RFXSC_XMT_PWR_LO 0
`define RFXSC_XMT_RESET 8'h00
// charge time: base 30 ms, doubled per field step
`define RFXSC_CLK_KHZ 40000
`define RFXSC_CP_BASE_MS 30
`define RFXSC_CP_BASE_CYCLES (`RFXSC_CP_BASE_MS * `RFXSC_CLK_KHZ)
// apb register offsets of the controller
`define RFXSC_APB_CMD 12'h000
`define RFXSC_APB_STATUS 12'h004
`define RFXSC_APB_IRQ_STATUS 12'h008
`define RFXSC_APB_IRQ_CLEAR 12'h00c
`define RFXSC_APB_IRQ_ENABLE 12'h010
// command word fields
`define RFXSC_CMD_DATA_LO 0
`define RFXSC_CMD_ADDR_LO 8
`define RFXSC_CMD_READ_BIT 16
// interrupt bits
`define RFXSC_IRQ_WR_DONE 0
`define RFXSC_IRQ_RD_DONE 1
`endif

// >>> design/rfxsc_pkg.sv
// types shared by the rf control device and its controller
// assumes rfxsc_params.svh for the numbers
package rfxsc_pkg;
  typedef logic [3:0] rfxsc_addr_t;
  typedef logic [7:0] rfxsc_byte_t;
  typedef enum logic [1:0] {
    RFXSC_CP_30MS,
    RFXSC_CP_60MS,
    RFXSC_CP_120MS,
    RFXSC_CP_240MS
  } rfxsc_cpt_t;
  typedef enum {RFXSC_IDLE, RFXSC_WAIT_READ} rfxsc_state_t;
endpackage : rfxsc_pkg

// >>> design/rfxsc_link_if.sv
// register link between controller and rf control device
// assumes both ends run on the same clock; writes and reads are one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
interface rfxsc_link_if;
  logic wr;
  logic rd;
  rfxsc_pkg::rfxsc_addr_t addr;
  rfxsc_pkg::rfxsc_byte_t wdata;
  rfxsc_pkg::rfxsc_byte_t rdata;
  logic rvalid;
  modport ctrl (output wr, output rd, output addr, output wdata, input rdata, input rvalid);
  modport dev (input wr, input rd, input addr, input wdata, output rdata, output rvalid);
endinterface : rfxsc_link_if
`default_nettype wire

// >>> design/rfxsc_device.sv
// rf supply select, charge pump control and transmit control registers
// assumes link strobes synchronous to CLOCK; event inputs are one-cycle pulses
//
// The APB interface to the registers was decided locally.
`include "rfxsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rfxsc_device #(
  parameter logic [23:0] CP_BASE_CYCLES = 24'(`RFXSC_CP_BASE_CYCLES)
) (
  rfxsc_link_if.dev link,
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CHARGE_TIME_EXPIRED,
  input wire logic VOLTAGE_LIMIT_TRIP,
  input wire logic PLL_LOCKED,
  input wire logic TX_DONE,
  input wire logic TX_ERROR,
  input wire logic TX_DATA_DIRECT,
  input wire logic TX_DATA_BUFFER,
  output logic SUPPLY_ANALOG_EN,
  output logic SUPPLY_CAP_EN,
  output logic PUMP_RUN,
  output logic [1:0] CHARGE_TIME_SEL,
  output logic ENC_POLARITY,
  output logic ENC_BIPHASE,
  output logic DATA_SOURCE_BUFFER,
  output logic TX_START,
  output logic TX_BUSY,
  output logic [4:0] PA_LEVEL,
  output logic TX_DATA_OUT
);
  logic analog_supply_select_r;
  logic capacitor_supply_select_r;
  logic charge_pump_enable_r;
  rfxsc_pkg::rfxsc_cpt_t charge_time_field_r;
  logic data_source_select_r;
  logic enc_pol_r;
  logic enc_code_r;
  logic send_r;
  logic transmit_error_flag_r;
  logic ready_to_send_flag_r;
  logic [4:0] amplifier_power_level_r;
  logic [23:0] cp_cnt_r;
  logic [23:0] cp_limit;
  logic cp_timer_done;
  logic sup_wr;
  logic xmt_wr;
  logic start_send;
  logic tx_start_r;
  logic tx_data_r;
  rfxsc_pkg::rfxsc_byte_t rdata_r;
  rfxsc_pkg::rfxsc_byte_t sup_val;
  rfxsc_pkg::rfxsc_byte_t xmt_val;
  logic rvalid_r;

  // address decode
  assign sup_wr = link.wr && (link.addr == `RFXSC_ADDR_SUPPLY);
  assign xmt_wr = link.wr && (link.addr == `RFXSC_ADDR_XMT);
  assign start_send = xmt_wr && link.wdata[`RFXSC_XMT_SEND_BIT];

  // supply select bits
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      analog_supply_select_r <= 1'(`RFXSC_SUP_RESET >> `RFXSC_SUP_ANALOG_SUPPLY_SELECT_BIT);
      capacitor_supply_select_r <= 1'b0;
    end else if (sup_wr) begin
      analog_supply_select_r <= link.wdata[`RFXSC_SUP_ANALOG_SUPPLY_SELECT_BIT];
      capacitor_supply_select_r <= link.wdata[`RFXSC_SUP_CAP_BIT];
    end
  end

  // charge time, encoding and data source settings
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      charge_time_field_r <= rfxsc_pkg::RFXSC_CP_30MS;
      data_source_select_r <= 1'b0;
      enc_pol_r <= 1'b0;
      enc_code_r <= 1'b0;
    end else if (sup_wr) begin
      charge_time_field_r <= rfxsc_pkg::rfxsc_cpt_t'(
        link.wdata[`RFXSC_SUP_CPT_HI:`RFXSC_SUP_CPT_LO]);
      data_source_select_r <= link.wdata[`RFXSC_SUP_SRC_BIT];
      enc_pol_r <= link.wdata[`RFXSC_SUP_POL_BIT];
      enc_code_r <= link.wdata[`RFXSC_SUP_CODE_BIT];
    end
  end

  // charge pump run length: base time doubled per field step
  assign cp_limit = CP_BASE_CYCLES << charge_time_field_r;
  assign cp_timer_done = charge_pump_enable_r && (cp_cnt_r >= cp_limit - 24'h000001);

  always_ff @(posedge CLOCK) begin
    if (!RSTN || !charge_pump_enable_r) begin
      cp_cnt_r <= 24'h000000;
    end else if (!cp_timer_done) begin
      cp_cnt_r <= cp_cnt_r + 24'h000001;
    end
  end

  // charge pump enable: software write wins over hardware stop
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      charge_pump_enable_r <= 1'b0;
    end else if (sup_wr) begin
      charge_pump_enable_r <= link.wdata[`RFXSC_SUP_PUMP_BIT];
    end else if (cp_timer_done || CHARGE_TIME_EXPIRED || VOLTAGE_LIMIT_TRIP) begin
      charge_pump_enable_r <= 1'b0;
    end
  end

  // power level
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      amplifier_power_level_r <= 5'h00;
    end else if (xmt_wr) begin
      amplifier_power_level_r <= link.wdata[`RFXSC_XMT_PWR_HI:`RFXSC_XMT_PWR_LO];
    end
  end

  // send bit: a new start wins over the end of the previous frame
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      send_r <= 1'b0;
      tx_start_r <= 1'b0;
    end else begin
      tx_start_r <= start_send;
      if (start_send) begin
        send_r <= 1'b1;
      end else if (TX_DONE) begin
        send_r <= 1'b0;
      end
    end
  end

  // error flag: a reported error wins over the clear by a start
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      transmit_error_flag_r <= 1'b0;
    end else if (TX_ERROR) begin
      transmit_error_flag_r <= 1'b1;
    end else if (start_send) begin
      transmit_error_flag_r <= 1'b0;
    end
  end

  // ready to send follows the lock indication
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      ready_to_send_flag_r <= 1'b0;
    end else begin
      ready_to_send_flag_r <= PLL_LOCKED;
    end
  end

  // transmit data source
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      tx_data_r <= 1'b0;
    end else begin
      tx_data_r <= data_source_select_r ? TX_DATA_BUFFER : TX_DATA_DIRECT;
    end
  end

  // read back
  assign sup_val = {data_source_select_r, enc_pol_r, enc_code_r, charge_time_field_r,
    analog_supply_select_r, capacitor_supply_select_r, charge_pump_enable_r};
  assign xmt_val = {send_r, transmit_error_flag_r, ready_to_send_flag_r,
    amplifier_power_level_r};

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= link.rd;
      if (link.rd) begin
        if (link.addr == `RFXSC_ADDR_SUPPLY) begin
          rdata_r <= sup_val;
        end else if (link.addr == `RFXSC_ADDR_XMT) begin
          rdata_r <= xmt_val;
        end else begin
          rdata_r <= 8'h00;
        end
      end
    end
  end

  assign link.rdata = rdata_r;
  assign link.rvalid = rvalid_r;

  // outputs
  assign SUPPLY_ANALOG_EN = analog_supply_select_r;
  assign SUPPLY_CAP_EN = capacitor_supply_select_r;
  assign PUMP_RUN = charge_pump_enable_r;
  assign CHARGE_TIME_SEL = charge_time_field_r;
  assign ENC_POLARITY = enc_pol_r;
  assign ENC_BIPHASE = enc_code_r;
  assign DATA_SOURCE_BUFFER = data_source_select_r;
  assign TX_START = tx_start_r;
  assign TX_BUSY = send_r;
  assign PA_LEVEL = amplifier_power_level_r;
  assign TX_DATA_OUT = tx_data_r;
endmodule : rfxsc_device
`default_nettype wire

// >>> design/rfxsc_ctrl.sv
// controller end: apb slave that issues link writes and reads to the rf device
// assumes apb signals synchronous to CLOCK; software
`include "rfxsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rfxsc_ctrl (
  rfxsc_link_if.ctrl link,
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);
  rfxsc_pkg::rfxsc_state_t state_r;
  logic wr_r;
  logic rd_r;
  rfxsc_pkg::rfxsc_addr_t addr_r;
  rfxsc_pkg::rfxsc_byte_t wdata_r;
  rfxsc_pkg::rfxsc_byte_t rbyte_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_enable_r;
  logic [31:0] prdata_r;
  logic access;
  logic mapped;
  logic cmd_go;
  logic wr_done;

  assign access = PSEL && PENABLE;
  assign mapped = (PADDR == `RFXSC_APB_CMD) || (PADDR == `RFXSC_APB_STATUS) ||
    (PADDR == `RFXSC_APB_IRQ_STATUS) || (PADDR == `RFXSC_APB_IRQ_CLEAR) ||
    (PADDR == `RFXSC_APB_IRQ_ENABLE);
  // commands while a read is pending are ignored
  assign cmd_go = access && PWRITE && (PADDR == `RFXSC_APB_CMD) &&
    (state_r == rfxsc_pkg::RFXSC_IDLE);
  assign wr_done = wr_r;

  // link strobes
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= 4'h0;
      wdata_r <= 8'h00;
    end else begin
      wr_r <= cmd_go && !PWDATA[`RFXSC_CMD_READ_BIT];
      rd_r <= cmd_go && PWDATA[`RFXSC_CMD_READ_BIT];
      if (cmd_go) begin
        addr_r <= PWDATA[`RFXSC_CMD_ADDR_LO +: 4];
        wdata_r <= PWDATA[`RFXSC_CMD_DATA_LO +: 8];
      end
    end
  end

  // read tracking
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      state_r <= rfxsc_pkg::RFXSC_IDLE;
      rbyte_r <= 8'h00;
    end else begin
      unique case (state_r)
        rfxsc_pkg::RFXSC_IDLE: begin
          if (cmd_go && PWDATA[`RFXSC_CMD_READ_BIT]) begin
            state_r <= rfxsc_pkg::RFXSC_WAIT_READ;
          end
        end
        rfxsc_pkg::RFXSC_WAIT_READ: begin
          if (link.rvalid) begin
            rbyte_r <= link.rdata;
            state_r <= rfxsc_pkg::RFXSC_IDLE;
          end
        end
      endcase
    end
  end

  // interrupt status: a new event wins over a clear
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      irq_status_r <= 2'h0;
    end else begin
      irq_status_r[`RFXSC_IRQ_WR_DONE] <= wr_done ||
        (irq_status_r[`RFXSC_IRQ_WR_DONE] && !(access && PWRITE &&
        (PADDR == `RFXSC_APB_IRQ_CLEAR) && PWDATA[`RFXSC_IRQ_WR_DONE]));
      irq_status_r[`RFXSC_IRQ_RD_DONE] <= (state_r == rfxsc_pkg::RFXSC_WAIT_READ && link.rvalid) ||
        (irq_status_r[`RFXSC_IRQ_RD_DONE] && !(access && PWRITE &&
        (PADDR == `RFXSC_APB_IRQ_CLEAR) && PWDATA[`RFXSC_IRQ_RD_DONE]));
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      irq_enable_r <= 2'h0;
    end else if (access && PWRITE && PADDR == `RFXSC_APB_IRQ_ENABLE) begin
      irq_enable_r <= PWDATA[1:0];
    end
  end

  // apb read data
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      prdata_r <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        `RFXSC_APB_STATUS: prdata_r <= {23'h000000,
          state_r == rfxsc_pkg::RFXSC_WAIT_READ, rbyte_r};
        `RFXSC_APB_IRQ_STATUS: prdata_r <= {30'h00000000, irq_status_r};
        `RFXSC_APB_IRQ_ENABLE: prdata_r <= {30'h00000000, irq_enable_r};
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;
  assign IRQ = |(irq_status_r & irq_enable_r);
  assign link.wr = wr_r;
  assign link.rd = rd_r;
  assign link.addr = addr_r;
  assign link.wdata = wdata_r;
endmodule : rfxsc_ctrl
`default_nettype wire

// >>> dv/rfxsc_checker.sv
// assertions on the register link and rf device outputs
// assumes one clock; placed by the bench beside the link
`include "rfxsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rfxsc_checker (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic wr,
  input wire logic rd,
  input wire rfxsc_pkg::rfxsc_addr_t addr,
  input wire rfxsc_pkg::rfxsc_byte_t wdata,
  input wire logic rvalid,
  input wire logic CHARGE_TIME_EXPIRED,
  input wire logic VOLTAGE_LIMIT_TRIP,
  input wire logic TX_DONE,
  input wire logic SUPPLY_ANALOG_EN,
  input wire logic SUPPLY_CAP_EN,
  input wire logic PUMP_RUN,
  input wire logic [1:0] CHARGE_TIME_SEL,
  input wire logic TX_START,
  input wire logic TX_BUSY,
  input wire logic [4:0] PA_LEVEL
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  logic sup_wr;
  logic xmt_wr;
  logic pump_evt;
  assign sup_wr = wr && addr == `RFXSC_ADDR_SUPPLY;
  assign xmt_wr = wr && addr == `RFXSC_ADDR_XMT;
  assign pump_evt = CHARGE_TIME_EXPIRED || VOLTAGE_LIMIT_TRIP;
  read_answer_a: assert property (rd |=> rvalid)
    else $error("read without answer");
  answer_cause_a: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  supply_select_a: assert property (
    sup_wr |=> SUPPLY_ANALOG_EN == $past(wdata[2]) && SUPPLY_CAP_EN == $past(wdata[1]))
    else $error("supply enables differ from write");
  pump_write_a: assert property (sup_wr |=> PUMP_RUN == $past(wdata[0]))
    else $error("pump differs from write");
  charge_time_a: assert property (sup_wr |=> CHARGE_TIME_SEL == $past(wdata[4:3]))
    else $error("charge time differs from write");
  pump_event_a: assert property (pump_evt && !sup_wr |=> !PUMP_RUN)
    else $error("pump runs after stop event");
  send_start_a: assert property (
    xmt_wr && wdata[7] |=> TX_BUSY && TX_START ##1 !TX_START)
    else $error("send did not start one pulse");
  start_cause_a: assert property (TX_START |-> $past(xmt_wr) && $past(wdata[7]))
    else $error("start pulse without send");
  send_done_a: assert property (TX_DONE && !(xmt_wr && wdata[7]) |=> !TX_BUSY)
    else $error("busy after done");
  busy_hold_a: assert property (TX_BUSY && !TX_DONE |=> TX_BUSY)
    else $error("busy dropped early");
  power_level_a: assert property (xmt_wr |=> PA_LEVEL == $past(wdata[4:0]))
    else $error("power level differs from write");
  pump_event_c: cover property (pump_evt && PUMP_RUN);
  send_done_c: cover property (TX_BUSY && TX_DONE);
  read_c: cover property (rd ##1 rvalid);
endmodule : rfxsc_checker
`default_nettype wire

// >>> dv/test_rf_tx_supply_and_transmit_control.sv
// bench: apb traffic into the controller, device joined over the link
// assumes the design compiled first; pump base cut to 10 cycles
`include "rfxsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module test_rf_tx_supply_and_transmit_control;
  localparam int BASE = 10;
  logic CLOCK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, IRQ, last_err;
  logic CHARGE_TIME_EXPIRED = 1'b0, VOLTAGE_LIMIT_TRIP = 1'b0, PLL_LOCKED = 1'b0;
  logic TX_DONE = 1'b0, TX_ERROR = 1'b0, TX_DATA_DIRECT = 1'b0, TX_DATA_BUFFER = 1'b0;
  logic SUPPLY_ANALOG_EN, SUPPLY_CAP_EN, PUMP_RUN, ENC_POLARITY, ENC_BIPHASE;
  logic DATA_SOURCE_BUFFER, TX_START, TX_BUSY, TX_DATA_OUT;
  logic [1:0] CHARGE_TIME_SEL;
  logic [4:0] PA_LEVEL;
  int num_errors = 0;
  int tests_run = 0;
  rfxsc_link_if link ();
  rfxsc_ctrl i_rfxsc_ctrl (.link(link), .CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
  rfxsc_device #(.CP_BASE_CYCLES(24'(BASE))) i_rfxsc_device (.link(link), .CLOCK(CLOCK),
    .RSTN(RSTN), .CHARGE_TIME_EXPIRED(CHARGE_TIME_EXPIRED),
    .VOLTAGE_LIMIT_TRIP(VOLTAGE_LIMIT_TRIP), .PLL_LOCKED(PLL_LOCKED), .TX_DONE(TX_DONE),
    .TX_ERROR(TX_ERROR), .TX_DATA_DIRECT(TX_DATA_DIRECT), .TX_DATA_BUFFER(TX_DATA_BUFFER),
    .SUPPLY_ANALOG_EN(SUPPLY_ANALOG_EN), .SUPPLY_CAP_EN(SUPPLY_CAP_EN), .PUMP_RUN(PUMP_RUN),
    .CHARGE_TIME_SEL(CHARGE_TIME_SEL), .ENC_POLARITY(ENC_POLARITY), .ENC_BIPHASE(ENC_BIPHASE),
    .DATA_SOURCE_BUFFER(DATA_SOURCE_BUFFER), .TX_START(TX_START), .TX_BUSY(TX_BUSY),
    .PA_LEVEL(PA_LEVEL), .TX_DATA_OUT(TX_DATA_OUT));
  rfxsc_checker i_rfxsc_checker (.CLOCK(CLOCK), .RSTN(RSTN), .wr(link.wr), .rd(link.rd),
    .addr(link.addr), .wdata(link.wdata), .rvalid(link.rvalid),
    .CHARGE_TIME_EXPIRED(CHARGE_TIME_EXPIRED), .VOLTAGE_LIMIT_TRIP(VOLTAGE_LIMIT_TRIP),
    .TX_DONE(TX_DONE), .SUPPLY_ANALOG_EN(SUPPLY_ANALOG_EN), .SUPPLY_CAP_EN(SUPPLY_CAP_EN),
    .PUMP_RUN(PUMP_RUN), .CHARGE_TIME_SEL(CHARGE_TIME_SEL), .TX_START(TX_START),
    .TX_BUSY(TX_BUSY), .PA_LEVEL(PA_LEVEL));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    last_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wait_irq(input int b);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      apb(1'b0, `RFXSC_APB_IRQ_STATUS, 32'h0, q);
      n++;
    end while (q[b] !== 1'b1 && n < 20);
    check(32'(q[b]), 32'h1);
    apb(1'b1, `RFXSC_APB_IRQ_CLEAR, 32'h1 << b, q);
  endtask : wait_irq
  task automatic dev_wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, `RFXSC_APB_CMD, {20'h0, a, d}, q);
    wait_irq(`RFXSC_IRQ_WR_DONE);
  endtask : dev_wr
  task automatic dev_rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    apb(1'b1, `RFXSC_APB_CMD, {15'h0, 1'b1, 4'h0, a, 8'h00}, q);
    wait_irq(`RFXSC_IRQ_RD_DONE);
    apb(1'b0, `RFXSC_APB_STATUS, 32'h0, q);
    check(q[7:0], e);
  endtask : dev_rd
  task automatic test_reset();
    check({SUPPLY_ANALOG_EN, SUPPLY_CAP_EN, PUMP_RUN, CHARGE_TIME_SEL}, 5'h10);
    check({TX_BUSY, PA_LEVEL, IRQ}, 7'h00);
    check({DATA_SOURCE_BUFFER, ENC_POLARITY, ENC_BIPHASE, TX_START, TX_DATA_OUT}, 5'h00);
    dev_rd(4'h2, 8'h04);
    dev_rd(4'h3, 8'h00);
  endtask : test_reset
  task automatic test_supply();
    dev_wr(4'h2, 8'h02);
    check({SUPPLY_ANALOG_EN, SUPPLY_CAP_EN}, 2'b01);
    dev_rd(4'h2, 8'h02);
    dev_wr(4'h2, 8'h04);
    check({SUPPLY_ANALOG_EN, SUPPLY_CAP_EN}, 2'b10);
  endtask : test_supply
  task automatic test_pump();
    logic [31:0] q;
    int n;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `RFXSC_APB_CMD, {20'h0, 4'h2, 3'b000, 2'(c), 3'b101}, q);
      for (n = 0; n < 20 && PUMP_RUN !== 1'b1; n++)
        @(posedge CLOCK);
      for (n = 0; n < 200 && PUMP_RUN === 1'b1; n++)
        @(posedge CLOCK);
      check(32'(n == (BASE << c) || n == (BASE << c) + 1), 32'h1);
      wait_irq(`RFXSC_IRQ_WR_DONE);
    end
    for (int i = 0; i < 3; i++) begin
      dev_wr(4'h2, 8'h1d);
      check(PUMP_RUN, 1'b1);
      if (i < 2) begin
        {CHARGE_TIME_EXPIRED, VOLTAGE_LIMIT_TRIP} <= 2'(i + 1);
        @(posedge CLOCK);
        {CHARGE_TIME_EXPIRED, VOLTAGE_LIMIT_TRIP} <= 2'b00;
        @(posedge CLOCK);
      end else begin
        dev_wr(4'h2, 8'h04);
      end
      check(PUMP_RUN, 1'b0);
    end
  endtask : test_pump
  task automatic test_send();
    dev_wr(4'h3, 8'h8e);
    check({TX_BUSY, PA_LEVEL}, 6'h2e);
    TX_ERROR <= 1'b1;
    @(posedge CLOCK);
    TX_ERROR <= 1'b0;
    dev_rd(4'h3, 8'hce);
    TX_DONE <= 1'b1;
    @(posedge CLOCK);
    TX_DONE <= 1'b0;
    @(posedge CLOCK);
    check(TX_BUSY, 1'b0);
    dev_rd(4'h3, 8'h4e);
    PLL_LOCKED <= 1'b1;
    dev_wr(4'h3, 8'h8d);
    dev_rd(4'h3, 8'had);
  endtask : test_send
  task automatic test_source();
    TX_DATA_BUFFER <= 1'b1;
    dev_wr(4'h2, 8'he4);
    check({DATA_SOURCE_BUFFER, ENC_POLARITY, ENC_BIPHASE, TX_DATA_OUT}, 4'hf);
    dev_wr(4'h2, 8'h04);
    check({DATA_SOURCE_BUFFER, ENC_POLARITY, ENC_BIPHASE, TX_DATA_OUT}, 4'h0);
    TX_DATA_DIRECT <= 1'b1;
    repeat (2) @(posedge CLOCK);
    check(TX_DATA_OUT, 1'b1);
  endtask : test_source
  task automatic test_irq();
    logic [31:0] q;
    int n;
    apb(1'b1, `RFXSC_APB_IRQ_ENABLE, 32'h1, q);
    apb(1'b1, `RFXSC_APB_CMD, {20'h0, 4'h3, 8'h0e}, q);
    for (n = 0; n < 20 && IRQ !== 1'b1; n++)
      @(posedge CLOCK);
    check(IRQ, 1'b1);
    apb(1'b1, `RFXSC_APB_IRQ_CLEAR, 32'h1, q);
    @(posedge CLOCK);
    check(IRQ, 1'b0);
    apb(1'b1, `RFXSC_APB_IRQ_ENABLE, 32'h0, q);
    apb(1'b1, `RFXSC_APB_CMD, {20'h0, 4'h3, 8'h0e}, q);
    repeat (6) @(posedge CLOCK);
    check(IRQ, 1'b0);
    apb(1'b0, `RFXSC_APB_IRQ_STATUS, 32'h0, q);
    check(q[1:0], 2'b01);
    apb(1'b1, `RFXSC_APB_IRQ_CLEAR, 32'h1, q);
    apb(1'b0, 12'h020, 32'h0, q);
    check(last_err, 1'b1);
    dev_rd(4'h7, 8'h00);
  endtask : test_irq
  initial begin
    forever #12.5 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    repeat (3) @(posedge CLOCK);
    RSTN <= 1'b1;
    test_reset();
    test_supply();
    test_pump();
    test_send();
    test_source();
    test_irq();
    finish_test();
  end
endmodule : test_rf_tx_supply_and_transmit_control
`default_nettype wire
